// ### core/hspc_top.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hspc_top #(
   parameter int POWERUP_CYCLES = hspc_pkg::POWERUP_CYC,
   parameter int DEGLITCH_CYCLES = hspc_pkg::DEGLITCH_CYC,
   parameter int CB_CYCLES      = hspc_pkg::CB_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        internal_supply_low_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        board_present_n_i,
   input  wire logic        on_ctrl_i,
   input  wire logic        backplane_reset_n_i,
   input  wire logic [3:0]  power_bad_i,
   input  wire logic [3:0]  uvlo_i,
   input  wire logic [3:0]  cb_over_i,
   input  wire logic [3:0]  ramp_done_i,
   input  wire logic [1:0]  cfg_mode_i,
   input  wire logic [1:0]  bus_addr_select_i,
   input  wire logic [3:0]  bus_addr_tri_i,
   input  wire logic [2:0]  gpio_i,
   output logic [2:0]       gpio_o,
   output logic [2:0]       gpio_oe_n_o,
   output logic [3:0]       switch_on_o,
   output logic             board_power_ok_n_o,
   output logic             board_power_ok_n_oe_n_o,
   output logic             slot_reset_n_o,
   output logic             slot_reset_n_oe_n_o,
   output logic             alert_n_o,
   output logic             alert_n_oe_n_o,
   output logic [1:0]       adc_sel_o,
   output logic [4:0]       bus_addr_o,
   output logic             level_3v3_o
);
   localparam int PW = $clog2(POWERUP_CYCLES + 1);
   localparam int DW = $clog2(DEGLITCH_CYCLES + 1);
   localparam int CW = $clog2(CB_CYCLES + 1);
   localparam int SW = 14;
   localparam int NSUP_L = hspc_pkg::NSUP;

   logic          rst;
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic [3:0]    pbad;
   logic [3:0]    uvlo;
   logic [1:0]    cfg;
   logic [3:0]    tri_sel;
   logic [3:0]    chk_mask;
   logic          inhibit;
   logic          bp_prev_reg;
   logic          on_prev_reg;
   logic          g1_prev_reg;
   logic          bp_fall;
   logic          bp_rise;
   logic          on_rise;
   logic          on_fall;
   logic          g1_chg;
   logic [PW-1:0] pu_cnt_reg;
   logic          pu_done_reg;
   logic          pu_fire;
   logic [3:0]    on_reg;
   logic [3:0]    on_next;
   logic          seq_reg;
   logic [3:0]    start_bits;
   logic [3:0]    armed_reg;
   logic [CW-1:0] cb_cnt_reg [NSUP_L];
   logic [3:0]    trip;
   logic [3:0]    fault1_reg;
   logic [1:0]    fault_log_second_reg;
   logic          fault_clr;
   logic [5:0]    alert_en_reg;
   logic [2:0]    gpio_drv_reg;
   logic [1:0]    adc_sel_reg;
   logic [DW-1:0] dg_cnt_reg;
   logic          ok_n_reg;
   logic          all_on;
   logic          all_good;
   logic          setup;
   logic          wr;
   logic          hit;
   logic [31:0]   rd_mux;
   logic [31:0]   prdata_reg;
   logic          pslverr_reg;
   logic [3:0]    tri_idx;

   assign rst = reset_i | internal_supply_low_i;

   always_ff @(posedge clk_i) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {power_bad_i, uvlo_i, cfg_mode_i, bus_addr_tri_i};
         sync2_reg <= sync1_reg;
      end
   end
   assign pbad    = sync2_reg[13:10];
   assign uvlo    = sync2_reg[9:6];
   assign cfg     = sync2_reg[5:4];
   assign tri_sel = sync2_reg[3:0];

   // negative supply checks dropped when config pin not grounded
   assign chk_mask    = (cfg == hspc_pkg::CFG_GND) ? 4'hF : 4'h7;
   assign level_3v3_o = (cfg == hspc_pkg::CFG_HIGH);
   assign inhibit     = |(uvlo & chk_mask);

   // nine three-state combos fold to eight, times four two-state combos
   assign tri_idx    = 4'(tri_sel[3:2]) * 4'h3 + 4'(tri_sel[1:0]);
   assign bus_addr_o = {tri_idx[2:0], bus_addr_select_i};

   always_ff @(posedge clk_i) begin
      if (rst) begin
         // track board-present and general pin one levels in reset so release shows no false edge
         bp_prev_reg <= board_present_n_i;
         on_prev_reg <= 1'b0;
         g1_prev_reg <= gpio_i[0];
      end else begin
         bp_prev_reg <= board_present_n_i;
         on_prev_reg <= on_ctrl_i;
         g1_prev_reg <= gpio_i[0];
      end
   end
   assign bp_fall = bp_prev_reg & ~board_present_n_i;
   assign bp_rise = ~bp_prev_reg & board_present_n_i;
   assign on_rise = ~on_prev_reg & on_ctrl_i & pu_done_reg;
   assign on_fall = on_prev_reg & ~on_ctrl_i;
   assign g1_chg  = g1_prev_reg ^ gpio_i[0];

   // power-up delay; on-control rising edges before it are ignored, level decides at expiry
   always_ff @(posedge clk_i) begin
      if (rst) begin
         pu_cnt_reg  <= '0;
         pu_done_reg <= 1'b0;
      end else if (!pu_done_reg) begin
         pu_cnt_reg  <= pu_cnt_reg + PW'(1);
         pu_done_reg <= (pu_cnt_reg == PW'(POWERUP_CYCLES - 1));
      end
   end
   assign pu_fire = ~pu_done_reg & (pu_cnt_reg == PW'(POWERUP_CYCLES - 1));

   assign start_bits = seq_reg ? 4'h1 : 4'hF;
   assign setup = psel_i & ~penable_i;
   assign wr    = psel_i & penable_i & pwrite_i;

   always_comb begin
      on_next = on_reg;
      if (wr && paddr_i == hspc_pkg::OFS_CTRL)
         on_next = pwdata_i[3:0];
      if (seq_reg) begin
         for (int k = 0; k < NSUP_L - 1; k++) begin
            if (on_reg[k] && ramp_done_i[k])
               on_next[k+1] = 1'b1;
         end
      end
      if (pu_fire && on_ctrl_i)
         on_next = start_bits;
      if (on_rise || (bp_fall && on_ctrl_i))
         on_next = start_bits;
      if (on_fall || bp_rise || |trip)
         on_next = hspc_pkg::ON_RST;
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         on_reg  <= hspc_pkg::ON_RST;
         seq_reg <= hspc_pkg::SEQ_RST;
      end else begin
         on_reg <= on_next;
         if (wr && paddr_i == hspc_pkg::OFS_CTRL)
            seq_reg <= pwdata_i[hspc_pkg::CTRL_SEQ_POS];
      end
   end

   // switches gated by board presence and lockout, never by software alone
   assign switch_on_o = (board_present_n_i | inhibit) ? 4'h0 : on_reg;

   // breaker armed only once that supply's start-up ramp has ended
   generate
      for (genvar s = 0; s < NSUP_L; s++) begin : g_cb
         always_ff @(posedge clk_i) begin
            if (rst) begin
               armed_reg[s]  <= 1'b0;
               cb_cnt_reg[s] <= '0;
            end else begin
               if (!switch_on_o[s])
                  armed_reg[s] <= 1'b0;
               else if (ramp_done_i[s])
                  armed_reg[s] <= 1'b1;
               if (armed_reg[s] && cb_over_i[s] && !trip[s])
                  cb_cnt_reg[s] <= cb_cnt_reg[s] + CW'(1);
               else
                  cb_cnt_reg[s] <= '0;
            end
         end
         assign trip[s] = armed_reg[s] & cb_over_i[s] &
                          (cb_cnt_reg[s] == CW'(CB_CYCLES - 1));
      end
   endgenerate

   assign fault_clr = bp_fall | on_fall;

   // new events win over any clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst) begin
         fault1_reg <= '0;
         fault_log_second_reg <= '0;
      end else begin
         fault1_reg <= (fault1_reg & ~((wr && paddr_i == hspc_pkg::OFS_FAULT1)
                       ? pwdata_i[3:0] : 4'h0) & {4{~fault_clr}}) | trip;
         fault_log_second_reg[hspc_pkg::F2_BOARD_POS] <= (fault_log_second_reg[hspc_pkg::F2_BOARD_POS] &
            ~(wr && paddr_i == hspc_pkg::OFS_FAULT_LOG_SECOND && pwdata_i[hspc_pkg::F2_BOARD_POS])
            & ~fault_clr) | bp_fall | bp_rise;
         fault_log_second_reg[hspc_pkg::F2_GENERAL_PIN_ONE_POS] <= (fault_log_second_reg[hspc_pkg::F2_GENERAL_PIN_ONE_POS] &
            ~(wr && paddr_i == hspc_pkg::OFS_FAULT_LOG_SECOND && pwdata_i[hspc_pkg::F2_GENERAL_PIN_ONE_POS])
            & ~fault_clr) | g1_chg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         alert_en_reg <= hspc_pkg::ALERT_RST;
         gpio_drv_reg <= hspc_pkg::GPIO_RST;
         adc_sel_reg  <= '0;
      end else if (wr && paddr_i == hspc_pkg::OFS_ALERT) begin
         alert_en_reg <= pwdata_i[5:0];
      end else if (wr && paddr_i == hspc_pkg::OFS_GPIO) begin
         gpio_drv_reg <= pwdata_i[2:0];
         adc_sel_reg  <= pwdata_i[hspc_pkg::GPIO_SEL_LSB +: 2];
      end
   end

   assign alert_n_o      = 1'b0;
   assign alert_n_oe_n_o = ~|({fault_log_second_reg, fault1_reg} & alert_en_reg);
   assign gpio_o         = 3'h0;
   assign gpio_oe_n_o    = ~gpio_drv_reg;
   assign adc_sel_o      = adc_sel_reg;

   assign all_on   = &(switch_on_o | ~chk_mask);
   assign all_good = ~|(pbad & chk_mask);

   // switch loss drops ok at once; power-bad only after deglitch
   always_ff @(posedge clk_i) begin
      if (rst) begin
         ok_n_reg   <= 1'b1;
         dg_cnt_reg <= '0;
      end else if (!all_on) begin
         ok_n_reg   <= 1'b1;
         dg_cnt_reg <= '0;
      end else if (all_good) begin
         ok_n_reg   <= 1'b0;
         dg_cnt_reg <= '0;
      end else if (!ok_n_reg) begin
         if (dg_cnt_reg == DW'(DEGLITCH_CYCLES - 1)) begin
            ok_n_reg   <= 1'b1;
            dg_cnt_reg <= '0;
         end else begin
            dg_cnt_reg <= dg_cnt_reg + DW'(1);
         end
      end
   end

   assign board_power_ok_n_o      = 1'b0;
   assign board_power_ok_n_oe_n_o = ok_n_reg;
   assign slot_reset_n_o          = 1'b0;
   assign slot_reset_n_oe_n_o     = ~(ok_n_reg | ~backplane_reset_n_i);

   always_comb begin
      hit    = 1'b1;
      rd_mux = '0;
      case (paddr_i)
         hspc_pkg::OFS_CTRL:   rd_mux = 32'({seq_reg, on_reg});
         hspc_pkg::OFS_STATUS: rd_mux = 32'({cfg, on_ctrl_i, board_present_n_i,
                                  ~slot_reset_n_oe_n_o, ok_n_reg, uvlo, pbad,
                                  switch_on_o});
         hspc_pkg::OFS_FAULT1: rd_mux = 32'(fault1_reg);
         hspc_pkg::OFS_FAULT_LOG_SECOND: rd_mux = 32'(fault_log_second_reg);
         hspc_pkg::OFS_ALERT:  rd_mux = 32'(alert_en_reg);
         hspc_pkg::OFS_GPIO:   rd_mux = 32'({gpio_i, 2'b00, adc_sel_reg, 1'b0,
                                  gpio_drv_reg});
         hspc_pkg::OFS_ADDR:   rd_mux = 32'(bus_addr_o);
         default:              hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_mux;
         pslverr_reg <= ~hit;
      end
   end

   assign pready_o  = psel_i & penable_i;
   assign prdata_o  = prdata_reg;
   assign pslverr_o = pslverr_reg & psel_i & penable_i;
endmodule : hspc_top
`default_nettype wire

// ### core/hspc_pkg.sv
package hspc_pkg;
   // apb byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_FAULT1 = 8'h08;
   localparam logic [7:0] OFS_FAULT_LOG_SECOND = 8'h0C;
   localparam logic [7:0] OFS_ALERT  = 8'h10;
   localparam logic [7:0] OFS_GPIO   = 8'h14;
   localparam logic [7:0] OFS_ADDR   = 8'h18;
   // field positions
   localparam int CTRL_SEQ_POS   = 4;
   localparam int GPIO_SEL_LSB   = 4;
   localparam int GPIO_IN_LSB    = 8;
   localparam int F2_BOARD_POS   = 0;
   localparam int F2_GENERAL_PIN_ONE_POS   = 1;
   localparam int ALERT_F2_LSB   = 4;
   // supply order: 12V, 5V, 3.3V, -12V
   localparam int NSUP           = 4;
   localparam int SUP_NEG        = 3;
   // reset values
   localparam logic [3:0] ON_RST    = 4'h0;
   localparam logic       SEQ_RST   = 1'b0;
   localparam logic [5:0] ALERT_RST = 6'h00;
   localparam logic [2:0] GPIO_RST  = 3'h0;
   // configuration pin decode
   localparam logic [1:0] CFG_GND   = 2'h0;
   localparam logic [1:0] CFG_OPEN  = 2'h1;
   localparam logic [1:0] CFG_HIGH  = 2'h2;
   // timing
   localparam longint CLK_HZ        = 64'd25_000_000;
   localparam longint CLK_NS        = 64'd40;
   localparam longint POWERUP_MS    = 64'd100;
   localparam longint DEGLITCH_NS   = 64'd15_000;
   localparam longint CB_FILTER_NS  = 64'd22_000;
   localparam int POWERUP_CYC  = int'(POWERUP_MS * CLK_HZ / 64'd1000);
   localparam int DEGLITCH_CYC = int'((DEGLITCH_NS + CLK_NS - 64'd1) / CLK_NS);
   localparam int CB_CYC       = int'((CB_FILTER_NS + CLK_NS - 64'd1) / CLK_NS);
endpackage : hspc_pkg

// ### verification/hspc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_top_monitor #(
   parameter int DEGLITCH_CYCLES = 5
) (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       internal_supply_low_i,
   input wire logic       board_present_n_i,
   input wire logic       on_ctrl_i,
   input wire logic       backplane_reset_n_i,
   input wire logic [3:0] power_bad_i,
   input wire logic [3:0] uvlo_i,
   input wire logic [1:0] bus_addr_select_i,
   input wire logic [3:0] switch_on_o,
   input wire logic       board_power_ok_n_oe_n_o,
   input wire logic       slot_reset_n_oe_n_o,
   input wire logic [4:0] bus_addr_o
);
   logic rst;
   int   bad_cnt;
   assign rst = reset_i || internal_supply_low_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst);
   // run length of a bad 12V output; margin covers the two sync stages
   always_ff @(posedge clk_i) begin
      bad_cnt <= (power_bad_i[0] && !rst) ? bad_cnt + 1 : 0;
   end
   chk_absent_off: assert property (board_present_n_i |-> switch_on_o == 4'h0)
      else $error("switch on while board absent");
   chk_lockout_off: assert property ((|uvlo_i[2:0]) [*3] |-> switch_on_o == 4'h0)
      else $error("switch on during lockout");
   chk_ok_needs_on: assert property ($fell(board_power_ok_n_oe_n_o) |->
      $past(switch_on_o[2:0]) == 3'h7) else $error("board ok without all switches");
   chk_slot_reset: assert property (slot_reset_n_oe_n_o ==
      (!board_power_ok_n_oe_n_o && backplane_reset_n_i)) else $error("slot reset wrong");
   chk_ok_deglitch: assert property (bad_cnt > DEGLITCH_CYCLES + 4 |->
      board_power_ok_n_oe_n_o) else $error("board ok kept after power bad");
   chk_on_fall_off: assert property ($fell(on_ctrl_i) |=> switch_on_o == 4'h0)
      else $error("switches stay on after on-control fall");
   chk_addr_select: assert property ($stable(bus_addr_select_i) [*3] |->
      bus_addr_o[1:0] == bus_addr_select_i) else $error("address select bits wrong");
   chk_rail_reset: assert property (disable iff (reset_i) internal_supply_low_i |=>
      switch_on_o == 4'h0 && board_power_ok_n_oe_n_o) else $error("rail loss left state");
endmodule : hspc_top_monitor
bind hspc_top hspc_top_monitor #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) u_mon (.*);
`default_nettype wire

// ### verification/hspc_supply_model.sv
`timescale 1ns/1ps
`default_nettype none
module hspc_supply_model #(
   parameter int RAMP = 6
) (
   input  wire logic [3:0] switch_on_i,
   input  wire logic       clk_i,
   input  wire logic [3:0] force_bad_i,
   output logic [3:0]      ramp_done_o,
   output logic [3:0]      power_bad_o
);
   int cnt [4];
   // a switched-off supply falls at once, so a restart ramps from zero
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 4; k++) begin
         cnt[k] <= switch_on_i[k] ? cnt[k] + int'(cnt[k] < RAMP) : 0;
      end
   end
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         ramp_done_o[k] = cnt[k] >= RAMP;
         power_bad_o[k] = !ramp_done_o[k] || force_bad_i[k];
      end
   end
endmodule : hspc_supply_model
`default_nettype wire

// ### verification/hspc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, (e), (g)); end end
module hspc_top_tb_top;
   localparam int PU = 20;
   localparam int DG = 5;
   localparam int CB = 4;
   logic        clk_i, pready_o, pslverr_o, level_3v3_o, alert_n_o, alert_n_oe_n_o;
   logic        reset_i = 1'b1, internal_supply_low_i = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, seed, m;
   logic        board_power_ok_n_o, board_power_ok_n_oe_n_o, slot_reset_n_o, slot_reset_n_oe_n_o;
   logic        board_present_n_i = 1'b0, on_ctrl_i = 1'b1, backplane_reset_n_i = 1'b1;
   logic [3:0]  power_bad_i, ramp_done_i, switch_on_o, idx, force_bad = 4'h0;
   logic [3:0]  uvlo_i = 4'h0, cb_over_i = 4'h0, bus_addr_tri_i = 4'h0;
   logic [1:0]  cfg_mode_i = hspc_pkg::CFG_GND, bus_addr_select_i = 2'h0, adc_sel_o, t0, t1;
   logic [2:0]  gpio_i, gpio_o, gpio_oe_n_o;
   logic [4:0]  bus_addr_o;
   logic [32:0] e;
   logic [32:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          errors = 0, num_checks = 0;
   // released pins float up through the board pull-up
   assign gpio_i = {gpio_oe_n_o[2] !== 1'b0, gpio_oe_n_o[1] !== 1'b0, gpio_oe_n_o[0] !== 1'b0};
   hspc_top #(.POWERUP_CYCLES(PU), .DEGLITCH_CYCLES(DG), .CB_CYCLES(CB)) i_dut (.*);
   hspc_supply_model #(.RAMP(6)) i_sup (.clk_i(clk_i), .switch_on_i(switch_on_o),
      .force_bad_i(force_bad), .ramp_done_o(ramp_done_i), .power_bad_o(power_bad_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [32:0] stx(input logic [3:0] sw, input logic okn, input logic srs);
      return {19'h0, srs, okn, 8'h0, sw};
   endfunction : stx
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] ex, input logic [31:0] mk);
      int n;
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      if (!wr) begin
         exp_q.push_back(ex);
         msk_q.push_back(mk);
      end
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      `CHK("ready", 1'b1, pready_o)
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] ex, input logic [31:0] mk);
      apb(1'b0, a, 32'h0, ex, mk);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 32'h0);
   endtask : wr
   task automatic st(input logic [3:0] sw, input logic okn, input logic srs);
      rd(hspc_pkg::OFS_STATUS, stx(sw, okn, srs), 32'h300F);
   endtask : st
   always @(posedge clk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK("read", e, {pslverr_o, prdata_o & m})
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      complete_run();
   end
   initial begin
      seed = 32'h4D45;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(hspc_pkg::OFS_CTRL, 33'h0, 32'h1F);
      rd(8'h40, 33'h1_0000_0000, 32'hFFFF_FFFF);
      repeat (PU + 40) @(posedge clk_i);
      st(4'hF, 1'b0, 1'b0);
      backplane_reset_n_i <= 1'b0;
      st(4'hF, 1'b0, 1'b1);
      backplane_reset_n_i <= 1'b1;
      force_bad <= 4'h1;
      st(4'hF, 1'b0, 1'b0);
      repeat (DG + 6) @(posedge clk_i);
      st(4'hF, 1'b1, 1'b1);
      force_bad <= 4'h0;
      cb_over_i <= 4'h2;
      repeat (CB + 8) @(posedge clk_i);
      st(4'h0, 1'b1, 1'b1);
      rd(hspc_pkg::OFS_FAULT1, 33'h2, 32'hF);
      cb_over_i <= 4'h0;
      on_ctrl_i <= 1'b0;
      rd(hspc_pkg::OFS_FAULT1, 33'h0, 32'hF);
      wr(hspc_pkg::OFS_CTRL, 32'h10);
      on_ctrl_i <= 1'b1;
      st(4'h1, 1'b1, 1'b1);
      repeat (60) @(posedge clk_i);
      st(4'hF, 1'b0, 1'b0);
      board_present_n_i <= 1'b1;
      st(4'h0, 1'b1, 1'b1);
      rd(hspc_pkg::OFS_FAULT_LOG_SECOND, 33'h1, 32'h1);
      board_present_n_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      st(4'hF, 1'b0, 1'b0);
      uvlo_i <= 4'h4;
      repeat (4) @(posedge clk_i);
      rd(hspc_pkg::OFS_STATUS, 33'h0, 32'hF);
      uvlo_i <= 4'h0;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         t0 = seed[1:0] % 2'h3;
         t1 = seed[3:2] % 2'h3;
         idx = 4'(t1) * 4'h3 + 4'(t0);
         bus_addr_select_i <= seed[5:4];
         bus_addr_tri_i    <= {t1, t0};
         wr(hspc_pkg::OFS_ALERT, {26'h0, seed[11:6]});
         repeat (4) @(posedge clk_i);
         `CHK("addr", {idx[2:0], seed[5:4]}, bus_addr_o)
         `CHK("alert", ~seed[10], alert_n_oe_n_o)
         rd(hspc_pkg::OFS_ALERT, {27'h0, seed[11:6]}, 32'h3F);
      end
      on_ctrl_i <= 1'b0;
      internal_supply_low_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      internal_supply_low_i <= 1'b0;
      repeat (PU + 10) @(posedge clk_i);
      rd(hspc_pkg::OFS_CTRL, 33'h0, 32'h1F);
      rd(hspc_pkg::OFS_STATUS, 33'h0, 32'hF);
      wr(hspc_pkg::OFS_CTRL, 32'hF);
      rd(hspc_pkg::OFS_STATUS, 33'hF, 32'hF);
      wr(hspc_pkg::OFS_GPIO, 32'h21);
      repeat (2) @(posedge clk_i);
      `CHK("gpio_oe", 3'h6, gpio_oe_n_o)
      `CHK("adc_sel", 2'h2, adc_sel_o)
      rd(hspc_pkg::OFS_FAULT_LOG_SECOND, 33'h2, 32'h2);
      cfg_mode_i <= hspc_pkg::CFG_HIGH;
      repeat (4) @(posedge clk_i);
      `CHK("level", 1'b1, level_3v3_o)
      complete_run();
   end
endmodule : hspc_top_tb_top
`default_nettype wire
